// File: bench/ofd_fetch_model.sv
// Instruction fetch side model: an APB master that hands words to the decoder.
`timescale 1ns/1ps
module ofd_fetch_model (
  // Clock
  input wire logic mclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // The wait has no cap of its own; a dead slave is caught by the bench timeout.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: bench/tb_top.sv
// Self-checking testbench for the operand field decoder.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import ofd_pkg::*;
  logic mclk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic decode_done;
  logic illegal_instr;
  logic [31:0] rd;
  logic err;
  logic [15:0] b;
  logic [15:0] v;
  logic ok;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h1fad;
  logic [1:0] szs [4] = '{2'h1, 2'h1, 2'h0, 2'h3};
  logic [9:0] lits [4] = '{10'h0ff, 10'h100, 10'h3ff, 10'h3ff};
  logic [7:0] dsp_pairs [6] = '{8'h54, 8'h64, 8'h74, 8'h65, 8'h75, 8'h76};

  ofd_decoder dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .decode_done(decode_done), .illegal_instr(illegal_instr));
  ofd_fetch_model fetch_u (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [15:0] sext(input int k, input logic [15:0] x);
    case (k)
      0: return {{6{x[9]}}, x[9:0]};
      1: return x;
      default: return {{10{x[5]}}, x[5:0]};
    endcase
  endfunction

  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    fetch_u.xfer(wr, a, d, rd, err);
  endtask

  // Writes one word and waits for the decode to finish.
  task automatic dec(input logic [23:0] w);
    int n;
    rw(1'b1, OFD_ADDR_INSTR, {8'h00, w});
    n = 0;
    while (decode_done !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 20)
      fail_count++;
  endtask

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rw(1'b0, OFD_ADDR_PTR, 32'h0);
    `CHK(rd, 32'h0)
    rw(1'b0, 8'h38, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    rw(1'b1, 8'h02, 32'hffff_ffff);
    `CHK(err, 1'b1)
    rw(1'b1, OFD_ADDR_FLAGS, 32'h1ff);
    rw(1'b0, OFD_ADDR_FLAGS, 32'h0);
    `CHK(rd, 32'h1ff)
    rw(1'b1, OFD_ADDR_CTRL, 32'h0);
    rw(1'b1, OFD_ADDR_FLAGS, 32'h0);
    rw(1'b1, OFD_ADDR_RESULT, 32'h01a1_8000);
    rw(1'b0, OFD_ADDR_FLAGS, 32'h0);
    `CHK(rd, 32'h1a5)
    rw(1'b1, OFD_ADDR_CTRL, {27'h0, OFD_SIZE_BYTE, OFD_FMT_FILE});
    rw(1'b1, OFD_ADDR_RESULT, 32'h0000_1200);
    rw(1'b0, OFD_ADDR_FLAGS, 32'h0);
    `CHK(rd, 32'h190)
    dec(24'h20_5fff);
    rw(1'b0, OFD_ADDR_LIT, 32'h0);
    `CHK(rd, 32'h1fff)
    rw(1'b0, OFD_ADDR_STAT, 32'h0);
    `CHK(rd[3], 1'b1)
    `CHK(rd[13:6], 8'h20)
    for (int i = 0; i < 4; i++)
    begin
      rw(1'b1, OFD_ADDR_CTRL, {27'h0, szs[i], OFD_FMT_TEN_BIT_LITERAL});
      dec({8'h20, 2'b00, lits[i], 4'h3});
      `CHK(illegal_instr, szs[i] == OFD_SIZE_BYTE && lits[i] > 10'h0ff)
      rw(1'b0, OFD_ADDR_STAT, 32'h0);
      `CHK(rd[5:4], (szs[i] == 2'h3) ? OFD_SIZE_WORD : szs[i])
    end
    rw(1'b1, OFD_ADDR_CTRL, {29'h0, OFD_FMT_BIT_INDEX_FIELD});
    dec(24'h20_f003);
    rw(1'b0, OFD_ADDR_OPS, 32'h0);
    `CHK(rd[22:19], 4'hf)
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 3) ? 16'h0220 : 16'($random(seed));
      rw(1'b1, OFD_ADDR_CTRL, {25'h0, 2'(i % 3), 2'b00, OFD_FMT_SLIT});
      dec((i % 3 == 0) ? {8'h20, 2'b00, v[9:0], 4'h0} : {8'h20, v});
      rw(1'b0, OFD_ADDR_LIT, 32'h0);
      `CHK(rd, {16'h0, sext(i % 3, v)})
    end
    rw(1'b1, OFD_ADDR_CTRL, {25'h0, 2'h3, 2'b00, OFD_FMT_SLIT});
    dec(24'h20_0000);
    `CHK(illegal_instr, 1'b1)
    for (int f = 5; f < 7; f++)
    begin
      rw(1'b1, OFD_ADDR_CTRL, 32'(f));
      dec(24'h20_0600);
      `CHK(illegal_instr, f == 5)
      dec(24'h20_0700);
      `CHK(illegal_instr, 1'b1)
      dec(24'h20_00a5);
      rw(1'b0, OFD_ADDR_OPS, 32'h0);
      `CHK(rd[7:0], 8'ha5)
    end
    rw(1'b1, OFD_ADDR_CTRL, {29'h0, OFD_FMT_MAC});
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 8; p++)
      begin
        b = 16'($random(seed));
        rw(1'b1, OFD_ADDR_PTR, {16'h0, b});
        rw(1'b1, OFD_ADDR_PTR + 8'h0c, {16'h0, b});
        rw(1'b1, OFD_ADDR_PTR + 8'h14, {16'h0, b});
        ok = s ? (p <= 3) : (p <= 5);
        dec({5'h08, 1'(s), 2'b10, 1'(p), 3'(p), 4'h0, 4'h8, 4'(p)});
        `CHK(illegal_instr, !ok)
        rw(1'b0, OFD_ADDR_PTR, 32'h0);
        `CHK(rd[15:0], ok ? b + 16'h6 : b)
        rw(1'b0, OFD_ADDR_PTR + 8'h0c, 32'h0);
        `CHK(rd[15:0], ok ? b + 16'h4 : b)
        rw(1'b0, OFD_ADDR_PTR + 8'h14, 32'h0);
        `CHK(rd[15:0], ok ? b + 16'h2 : b)
        rw(1'b0, OFD_ADDR_OPS, 32'h0);
        if (ok)
        begin
          `CHK(rd[18], 1'(p))
          rw(1'b0, OFD_ADDR_MAC, 32'h0);
          `CHK(rd[25:0], {2'b10, 8'h80, 4'(4 + p % 4), 4'(4 + p / 4), s ? {2{4'(4 + p)}} : dsp_pairs[p]})
        end
      end
    dec(24'h43_10f0);
    `CHK(illegal_instr, 1'b1)
    rw(1'b1, OFD_ADDR_CTRL, {29'h0, OFD_FMT_PADDR});
    dec(24'h30_1234);
    rw(1'b0, OFD_ADDR_STAT, 32'h0);
    `CHK(rd[2:0], 3'b100)
    dec(24'h00_0005);
    `CHK(illegal_instr, 1'b0)
    rw(1'b0, OFD_ADDR_LIT, 32'h0);
    `CHK(rd, 32'h0005_1234)
    dec(24'h30_1235);
    dec(24'h00_0005);
    `CHK(illegal_instr, 1'b1)
    dec(24'h30_1234);
    dec(24'h01_0005);
    `CHK(illegal_instr, 1'b1)
    dec(24'h00_0000);
    rw(1'b0, OFD_ADDR_STAT, 32'h0);
    `CHK(rd[1:0], 2'b10)
    close_out();
  end
endmodule

// File: design/ofd_decoder.sv
// Operand field decoder with APB register access and pointer update logic.
// Function
// - Instruction word is 24 bits, upper 8 bits select the type.
// - Second word of a pair has zero upper byte; alone it is a no-op.
// - File register address spans thirteen bits, 0 to 0x1FFF.
// - File instruction with working-register destination writes W0.
// - Accumulator operand selects exactly accumulator A or B.
// - Write-back goes to W13 or to [W13] with W13 incremented by two.
// - Bit index field is four bits, positions 0 to 15.
// - Ten-bit literal is at most 255 in byte size, 1023 in word size.
// - Program address literal must be even.
// - Signed literals of 10, 16, 6 bits are sign extended.
// - Base, source, destination fields each select W0 to W15.
// - Square multiply accepts only W4*W4, W5*W5, W6*W6, W7*W7.
// - DSP multiply accepts only the six distinct pairs of W4 to W7.
// - X prefetch uses W8 or W9 with modifiers, W9+W12, or none.
// - Y prefetch uses W10 or W11 with modifiers, W11+W12, or none.
// - X prefetch destination is one of W4 to W7.
// - Y prefetch destination is one of W4 to W7.
// - DSP operands add register-offset indirect form to general forms.
// - General operands support direct, indirect, post and pre update forms.
// - Five arithmetic flags carry, half carry, negative, overflow, zero are kept.
// - Four DSP flags: overflow and saturation for each accumulator.
// - Size is byte, word or double word, word by default.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module ofd_decoder
  import ofd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decode status
  output logic decode_done,
  output logic illegal_instr
);
  ofd_state_type state_reg, state_next;
  logic [23:0] instr_reg;
  logic [7:0] ctrl_reg, opc;
  logic [31:0] ops_reg, ops_next, mac_reg, mac_next, rd_data;
  logic [22:0] lit_reg, lit_next;
  logic [15:0] first_low_reg, res;
  logic go_reg, ill_next, nop_reg, nop_next, default_work_reg_dest_reg, default_work_reg_dest_next;
  logic wr_en, rd_setup, mapped, ptr_hit, commit;
  logic [3:0] xcode, ycode;
  logic [2:0] fmt, pair, smode, dmode, ptr_idx;
  logic [1:0] size_reg, size_eff, result_writeback_target;
  logic [8:0] flags_reg;
  logic [15:0] ptr_reg [OFD_PTR_COUNT], delta [OFD_PTR_COUNT];
  logic [OFD_PTR_COUNT-1:0] upd_en;

  function automatic logic [15:0] pf_delta(input logic [3:0] code);
    logic [3:0] idx;
    idx = (code >= OFD_PF_SECOND) ? 4'(code - OFD_PF_SECOND) : code;
    unique case (idx)
      4'h0: pf_delta = 16'h0006;
      4'h1: pf_delta = 16'h0004;
      4'h2: pf_delta = 16'h0002;
      4'h4: pf_delta = 16'hfffa;
      4'h5: pf_delta = 16'hfffc;
      4'h6: pf_delta = 16'hfffe;
      default: pf_delta = 16'h0000;
    endcase
  endfunction

  assign opc = instr_reg[OFD_WORD_W-1:OFD_OPC_LSB];
  assign fmt = ctrl_reg[OFD_CTRL_FMT_LSB +: 3];
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable & ~pready;
  assign ptr_idx = 3'(paddr[4:2]);
  assign ptr_hit = (paddr >= OFD_ADDR_PTR) && (paddr[1:0] == 2'h0)
                   && ({5'h00, ptr_idx} < 8'(OFD_PTR_COUNT)) && (paddr[7:5] == 3'h1);
  assign mapped = ptr_hit || (paddr[1:0] == 2'h0 && paddr < OFD_ADDR_PTR);
  assign xcode = instr_reg[11:8];
  assign ycode = instr_reg[7:4];
  assign pair = instr_reg[14:12];
  assign smode = instr_reg[10:8];
  assign dmode = instr_reg[13:11];
  assign result_writeback_target = opc[1:0];
  assign res = pwdata[15:0];
  assign commit = go_reg & ~ill_next;
  // An unused size code falls back to word size.
  assign size_eff = (ctrl_reg[OFD_CTRL_SIZE_LSB +: 2] == OFD_SIZE_BYTE ||
                     ctrl_reg[OFD_CTRL_SIZE_LSB +: 2] == OFD_SIZE_DWORD)
                    ? ctrl_reg[OFD_CTRL_SIZE_LSB +: 2] : OFD_SIZE_WORD;

  // Operand decode of the word held in the instruction register.
  always_comb
  begin
    state_next = state_reg;
    ops_next = 32'h0000_0000;
    lit_next = 23'h000000;
    mac_next = 32'h0000_0000;
    ill_next = 1'b0;
    nop_next = 1'b0;
    default_work_reg_dest_next = 1'b0;
    if (state_reg == OFD_WAIT2)
    begin
      state_next = OFD_IDLE;
      if (opc != OFD_OPC_NOP)
        ill_next = 1'b1;
      lit_next = {instr_reg[OFD_PADDR_HI_W-1:0], first_low_reg};
      if (first_low_reg[0])
        ill_next = 1'b1;
    end
    else if (opc == OFD_OPC_NOP)
      nop_next = 1'b1;
    else
    begin
      unique case (fmt)
        OFD_FMT_FILE:
        begin
          lit_next = 23'(instr_reg[OFD_FILE_W-1:0] & OFD_FILE_MAX);
          default_work_reg_dest_next = instr_reg[OFD_FILE_TO_DEFAULT_WORK_REG_BIT];
          if (instr_reg[OFD_FILE_TO_DEFAULT_WORK_REG_BIT])
            ops_next[7:4] = OFD_DEFAULT_WORK_REG;
        end
        OFD_FMT_TEN_BIT_LITERAL:
        begin
          lit_next = 23'(instr_reg[OFD_TEN_BIT_LITERAL_LSB +: 10]);
          ops_next[7:4] = instr_reg[3:0];
          if (size_eff == OFD_SIZE_BYTE && instr_reg[OFD_TEN_BIT_LITERAL_LSB +: 10] > OFD_BYTE_LIT_MAX)
            ill_next = 1'b1;
        end
        OFD_FMT_BIT_INDEX_FIELD:
        begin
          ops_next[22:19] = instr_reg[OFD_BIT_INDEX_FIELD_LSB +: 4];
          ops_next[3:0] = instr_reg[3:0];
        end
        OFD_FMT_PADDR:
        begin
          // The high part arrives with the next word, so decoding waits for it.
          state_next = OFD_WAIT2;
          lit_next = 23'(instr_reg[15:0]);
        end
        OFD_FMT_SLIT:
        begin
          unique case (ctrl_reg[OFD_CTRL_SLIT_LSB +: 2])
            OFD_SLIT_10: lit_next = 23'(unsigned'({{6{instr_reg[13]}}, instr_reg[13:4]}));
            OFD_SLIT_16: lit_next = 23'(instr_reg[15:0]);
            OFD_SLIT_6: lit_next = 23'(unsigned'({{10{instr_reg[5]}}, instr_reg[5:0]}));
            default: ill_next = 1'b1;
          endcase
        end
        OFD_FMT_REG, OFD_FMT_DSP:
        begin
          ops_next[3:0] = instr_reg[3:0];
          ops_next[7:4] = instr_reg[7:4];
          ops_next[11:8] = instr_reg[15:12];
          ops_next[14:12] = smode;
          ops_next[17:15] = dmode;
          if (smode == OFD_MODE_BAD || dmode == OFD_MODE_BAD)
            ill_next = 1'b1;
          if (fmt == OFD_FMT_REG && (smode == OFD_MODE_OFFSET || dmode == OFD_MODE_OFFSET))
            ill_next = 1'b1;
        end
        OFD_FMT_MAC:
        begin
          ops_next[18] = instr_reg[15];
          if (opc[2])
          begin
            mac_next[3:0] = 4'(OFD_W4 + {1'b0, pair[1:0]});
            mac_next[7:4] = 4'(OFD_W4 + {1'b0, pair[1:0]});
            if (pair > OFD_SQR_MAX)
              ill_next = 1'b1;
          end
          else
          begin
            unique case (pair)
              3'h0: mac_next[7:0] = 8'h54;
              3'h1: mac_next[7:0] = 8'h64;
              3'h2: mac_next[7:0] = 8'h74;
              3'h3: mac_next[7:0] = 8'h65;
              3'h4: mac_next[7:0] = 8'h75;
              3'h5: mac_next[7:0] = 8'h76;
              default: ill_next = 1'b1;
            endcase
          end
          mac_next[11:8] = 4'(OFD_W4 + {2'h0, instr_reg[3:2]});
          mac_next[15:12] = 4'(OFD_W4 + {2'h0, instr_reg[1:0]});
          mac_next[19:16] = xcode;
          mac_next[23:20] = ycode;
          mac_next[25:24] = result_writeback_target;
          if (result_writeback_target == OFD_AWB_BAD)
            ill_next = 1'b1;
        end
        default: ill_next = 1'b1;
      endcase
    end
  end

  // Pointer deltas that the decoded word asks for.
  always_comb
  begin
    for (int i = 0; i < OFD_PTR_COUNT; i++)
    begin
      delta[i] = 16'h0000;
      upd_en[i] = 1'b0;
    end
    if (state_reg == OFD_IDLE && opc != OFD_OPC_NOP && fmt == OFD_FMT_MAC)
    begin
      if (xcode < OFD_PF_INDEXED)
      begin
        upd_en[(xcode >= OFD_PF_SECOND) ? OFD_SLOT_W9 : OFD_SLOT_W8] = 1'b1;
        delta[(xcode >= OFD_PF_SECOND) ? OFD_SLOT_W9 : OFD_SLOT_W8] = pf_delta(xcode);
      end
      if (ycode < OFD_PF_INDEXED)
      begin
        upd_en[(ycode >= OFD_PF_SECOND) ? OFD_SLOT_W11 : OFD_SLOT_W10] = 1'b1;
        delta[(ycode >= OFD_PF_SECOND) ? OFD_SLOT_W11 : OFD_SLOT_W10] = pf_delta(ycode);
      end
      if (result_writeback_target == OFD_AWB_POSTINC)
      begin
        upd_en[OFD_SLOT_W13] = 1'b1;
        delta[OFD_SLOT_W13] = OFD_AWB_STEP;
      end
    end
  end

  // Pointer file; an APB write wins over a decode update to the same slot.
  generate
    for (genvar g = 0; g < OFD_PTR_COUNT; g++)
    begin : g_ptr
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          ptr_reg[g] <= 16'h0000;
        else if (wr_en && ptr_hit && ptr_idx == 3'(g))
          ptr_reg[g] <= pwdata[15:0];
        else if (commit && upd_en[g])
          ptr_reg[g] <= 16'(ptr_reg[g] + delta[g]);
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      instr_reg <= 24'h000000;
      ctrl_reg <= 8'h00;
      go_reg <= 1'b0;
    end
    else
    begin
      go_reg <= wr_en && paddr == OFD_ADDR_INSTR;
      if (wr_en && paddr == OFD_ADDR_INSTR)
        instr_reg <= pwdata[OFD_WORD_W-1:0];
      if (wr_en && paddr == OFD_ADDR_CTRL)
        ctrl_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= OFD_IDLE;
      first_low_reg <= 16'h0000;
      ops_reg <= 32'h0000_0000;
      lit_reg <= 23'h000000;
      mac_reg <= 32'h0000_0000;
      nop_reg <= 1'b0;
      default_work_reg_dest_reg <= 1'b0;
      size_reg <= OFD_SIZE_WORD;
      illegal_instr <= 1'b0;
      decode_done <= 1'b0;
    end
    else
    begin
      decode_done <= go_reg;
      if (go_reg)
      begin
        state_reg <= state_next;
        if (state_reg == OFD_IDLE)
          first_low_reg <= instr_reg[15:0];
        ops_reg <= ops_next;
        lit_reg <= lit_next;
        mac_reg <= mac_next;
        nop_reg <= nop_next;
        default_work_reg_dest_reg <= default_work_reg_dest_next;
        size_reg <= size_eff;
        illegal_instr <= ill_next;
      end
    end
  end

  // Status flags; saturation bits stay set until software writes them.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      flags_reg <= 9'h000;
    else if (wr_en && paddr == OFD_ADDR_FLAGS)
      flags_reg <= pwdata[8:0];
    else if (wr_en && paddr == OFD_ADDR_RESULT)
    begin
      flags_reg[OFD_FLAG_C] <= pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_C];
      flags_reg[OFD_FLAG_DC] <= pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_DC];
      flags_reg[OFD_FLAG_OV] <= pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_OV];
      flags_reg[OFD_FLAG_N] <= (size_eff == OFD_SIZE_BYTE) ? res[7] : res[15];
      flags_reg[OFD_FLAG_Z] <= (size_eff == OFD_SIZE_BYTE) ? (res[7:0] == 8'h00)
                                                           : (res == 16'h0000);
      flags_reg[OFD_FLAG_OA] <= pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_OA];
      flags_reg[OFD_FLAG_OB] <= pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_OB];
      flags_reg[OFD_FLAG_SA] <= flags_reg[OFD_FLAG_SA] | pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_SA];
      flags_reg[OFD_FLAG_SB] <= flags_reg[OFD_FLAG_SB] | pwdata[OFD_RES_FLAG_LSB + OFD_FLAG_SB];
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (ptr_hit)
      rd_data = {16'h0000, ptr_reg[ptr_idx]};
    else
    begin
      unique case (paddr)
        OFD_ADDR_INSTR: rd_data = {8'h00, instr_reg};
        OFD_ADDR_CTRL: rd_data = {24'h000000, ctrl_reg};
        OFD_ADDR_OPS: rd_data = ops_reg;
        OFD_ADDR_LIT: rd_data = {9'h000, lit_reg};
        OFD_ADDR_MAC: rd_data = mac_reg;
        OFD_ADDR_STAT: rd_data = {18'h00000, opc, size_reg, default_work_reg_dest_reg,
                                  (state_reg == OFD_WAIT2), nop_reg, illegal_instr};
        OFD_ADDR_FLAGS: rd_data = {23'h000000, flags_reg};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // One wait-free access phase: pready rises for exactly the first access cycle.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~mapped;
      prdata <= (rd_setup && !pwrite && mapped) ? rd_data : 32'h0000_0000;
    end
  end

  ready_one_a: assert property (@(posedge mclk) disable iff (rst)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  unmapped_err_a: assert property (@(posedge mclk) disable iff (rst)
    rd_setup && !mapped |=> pslverr && pready)
    else $error("unmapped access not answered with error");
  nop_zero_a: assert property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_IDLE && opc == OFD_OPC_NOP |=> nop_reg && !illegal_instr)
    else $error("zero opcode not decoded as no-op");
  sqr_pair_a: assert property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_IDLE && opc != OFD_OPC_NOP && fmt == OFD_FMT_MAC
    && opc[2] && pair > OFD_SQR_MAX |=> illegal_instr)
    else $error("bad square pair accepted");
  byte_lit_a: assert property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_IDLE && opc != OFD_OPC_NOP && fmt == OFD_FMT_TEN_BIT_LITERAL
    && size_eff == OFD_SIZE_BYTE && instr_reg[13:4] > OFD_BYTE_LIT_MAX |=> illegal_instr)
    else $error("byte literal above limit accepted");
  awb_step_a: assert property (@(posedge mclk) disable iff (rst)
    commit && upd_en[OFD_SLOT_W13] && !wr_en
    |=> ptr_reg[OFD_SLOT_W13] == 16'($past(ptr_reg[OFD_SLOT_W13]) + OFD_AWB_STEP))
    else $error("write-back pointer not advanced by two");
  pf_commit_a: assert property (@(posedge mclk) disable iff (rst)
    commit && upd_en[OFD_SLOT_W8] && !wr_en
    |=> decode_done && ptr_reg[OFD_SLOT_W8] != $past(ptr_reg[OFD_SLOT_W8])
        || $past(delta[OFD_SLOT_W8]) == 16'h0000)
    else $error("prefetch pointer not updated with decode");
  default_work_reg_dest_a: assert property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_IDLE && opc != OFD_OPC_NOP && fmt == OFD_FMT_FILE
    && instr_reg[OFD_FILE_TO_DEFAULT_WORK_REG_BIT] |=> default_work_reg_dest_reg && ops_reg[7:4] == 4'h0)
    else $error("file result not routed to W0");
  odd_paddr_a: assert property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_WAIT2 && first_low_reg[0] |=> illegal_instr ##1 !decode_done)
    else $error("odd program address accepted");
  two_word_c: cover property (@(posedge mclk) disable iff (rst)
    go_reg && state_reg == OFD_WAIT2 ##1 !illegal_instr);
  mac_ok_c: cover property (@(posedge mclk) disable iff (rst)
    commit && fmt == OFD_FMT_MAC && upd_en[OFD_SLOT_W13]);
  illegal_c: cover property (@(posedge mclk) disable iff (rst) $rose(illegal_instr));
endmodule

// File: design/ofd_pkg.sv
// Constants, register map and field layouts shared by the operand field decoder.
package ofd_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFD_ADDR_INSTR = 8'h00;
  localparam logic [7:0] OFD_ADDR_CTRL = 8'h04;
  localparam logic [7:0] OFD_ADDR_OPS = 8'h08;
  localparam logic [7:0] OFD_ADDR_LIT = 8'h0c;
  localparam logic [7:0] OFD_ADDR_MAC = 8'h10;
  localparam logic [7:0] OFD_ADDR_STAT = 8'h14;
  localparam logic [7:0] OFD_ADDR_RESULT = 8'h18;
  localparam logic [7:0] OFD_ADDR_FLAGS = 8'h1c;
  localparam logic [7:0] OFD_ADDR_PTR = 8'h20;
  localparam int OFD_PTR_COUNT = 6;
  localparam logic [3:0] OFD_PTR_FIRST_REG = 4'h8;
  // Pointer slots: W8, W9, W10, W11, W12, W13.
  localparam int OFD_SLOT_W8 = 0;
  localparam int OFD_SLOT_W9 = 1;
  localparam int OFD_SLOT_W10 = 2;
  localparam int OFD_SLOT_W11 = 3;
  localparam int OFD_SLOT_W13 = 5;
  // Instruction word layout.
  localparam int OFD_WORD_W = 24;
  localparam int OFD_OPC_LSB = 16;
  localparam logic [7:0] OFD_OPC_NOP = 8'h00;
  localparam int OFD_FILE_W = 13;
  localparam logic [12:0] OFD_FILE_MAX = 13'h1fff;
  localparam int OFD_FILE_TO_DEFAULT_WORK_REG_BIT = 14;
  localparam logic [3:0] OFD_DEFAULT_WORK_REG = 4'h0;
  localparam int OFD_TEN_BIT_LITERAL_LSB = 4;
  localparam logic [9:0] OFD_BYTE_LIT_MAX = 10'h0ff;
  localparam int OFD_BIT_INDEX_FIELD_LSB = 12;
  localparam int OFD_PADDR_HI_W = 7;
  // Control register fields.
  localparam int OFD_CTRL_FMT_LSB = 0;
  localparam int OFD_CTRL_SIZE_LSB = 3;
  localparam int OFD_CTRL_SLIT_LSB = 5;
  localparam logic [2:0] OFD_FMT_FILE = 3'h0;
  localparam logic [2:0] OFD_FMT_TEN_BIT_LITERAL = 3'h1;
  localparam logic [2:0] OFD_FMT_BIT_INDEX_FIELD = 3'h2;
  localparam logic [2:0] OFD_FMT_PADDR = 3'h3;
  localparam logic [2:0] OFD_FMT_SLIT = 3'h4;
  localparam logic [2:0] OFD_FMT_REG = 3'h5;
  localparam logic [2:0] OFD_FMT_DSP = 3'h6;
  localparam logic [2:0] OFD_FMT_MAC = 3'h7;
  localparam logic [1:0] OFD_SIZE_WORD = 2'h0;
  localparam logic [1:0] OFD_SIZE_BYTE = 2'h1;
  localparam logic [1:0] OFD_SIZE_DWORD = 2'h2;
  localparam logic [1:0] OFD_SLIT_10 = 2'h0;
  localparam logic [1:0] OFD_SLIT_16 = 2'h1;
  localparam logic [1:0] OFD_SLIT_6 = 2'h2;
  // Addressing modes of source and destination operands.
  localparam logic [2:0] OFD_MODE_OFFSET = 3'h6;
  localparam logic [2:0] OFD_MODE_BAD = 3'h7;
  // Multiply pair codes: square codes 0..3, DSP codes 0..5.
  localparam logic [2:0] OFD_SQR_MAX = 3'h3;
  localparam logic [2:0] OFD_DSP_PAIR_MAX = 3'h5;
  localparam logic [3:0] OFD_W4 = 4'h4;
  // Prefetch field: 0..6 first register, 7..13 second, 14 indexed, 15 none.
  localparam logic [3:0] OFD_PF_SECOND = 4'h7;
  localparam logic [3:0] OFD_PF_INDEXED = 4'he;
  localparam logic [3:0] OFD_PF_NONE = 4'hf;
  // Write-back field in opcode low bits.
  localparam logic [1:0] OFD_AWB_NONE = 2'h0;
  localparam logic [1:0] OFD_AWB_POSTINC = 2'h2;
  localparam logic [1:0] OFD_AWB_BAD = 2'h3;
  localparam logic [15:0] OFD_AWB_STEP = 16'h0002;
  // Flag register bit positions.
  localparam int OFD_FLAG_C = 0;
  localparam int OFD_FLAG_DC = 1;
  localparam int OFD_FLAG_N = 2;
  localparam int OFD_FLAG_OV = 3;
  localparam int OFD_FLAG_Z = 4;
  localparam int OFD_FLAG_OA = 5;
  localparam int OFD_FLAG_OB = 6;
  localparam int OFD_FLAG_SA = 7;
  localparam int OFD_FLAG_SB = 8;
  localparam int OFD_RES_FLAG_LSB = 16;
  typedef enum logic [1:0] {
    OFD_IDLE = 2'b01,
    OFD_WAIT2 = 2'b10
  } ofd_state_type;
endpackage
